// *** src/interval_if.sv ***
/*
 * Carrier between the trigger selector and its interval timer.
 * Assumes both ends run on the same master clock.
 */
`timescale 1ns/100ps
interface interval_if;
    logic        restart;
    logic        enable;
    logic [23:0] interval_us;
    logic        tick;

    modport ctrl  (output restart, output enable, output interval_us,
                   input  tick);
    modport timer (input  restart, input  enable, input  interval_us,
                   output tick);
endinterface : interval_if

// *** src/interval_timer.sv ***
/*
 * Internal periodic trigger generator: microsecond prescaler and interval
 * counter. Assumes interval_us is already clamped to its legal range.
 */
`timescale 1ns/100ps
module interval_timer #(
    parameter int CYCLES_PER_US = trig_pkg::CYCLES_PER_US
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    interval_if.timer tmr
);

    logic [7:0]  pre_cnt;
    logic [23:0] us_cnt;
    wire         pre_last;
    wire         us_last;

    // Interval shrinking mid-period ends the period at the next prescaler wrap, never wraps
    assign pre_last = (pre_cnt == 8'(CYCLES_PER_US - 1));
    assign us_last  = (us_cnt >= tmr.interval_us - 24'h000001);
    assign tmr.tick = tmr.enable & ~tmr.restart & pre_last & us_last;

    // Counters clear on run and while disabled so the first period starts there;
    // no force request reaches them
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_cnt <= 8'h00;
            us_cnt  <= 24'h000000;
        end else if (tmr.restart || !tmr.enable) begin
            pre_cnt <= 8'h00;
            us_cnt  <= 24'h000000;
        end else if (pre_last) begin
            pre_cnt <= 8'h00;
            us_cnt  <= us_last ? 24'h000000 : us_cnt + 24'h000001;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    restart_clears_a: assert property (
        tmr.restart |=> (pre_cnt == 8'h00) && (us_cnt == 24'h000000) && !tmr.tick)
        else $error("timer did not restart on run");

    tick_single_a: assert property (
        tmr.tick |=> !tmr.tick)
        else $error("interval tick longer than one cycle");

    cover_tick_c: cover property (tmr.enable ##1 tmr.tick);

endmodule : interval_timer

// *** src/trig_pkg.sv ***
/*
 * Constants, register map and types of the trigger source selection block.
 * Assumes a 50 MHz master clock and a software port with one-cycle strobes.
 */
package trig_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_LEVEL     = 8'h04;
    localparam logic [7:0]  ADDR_INTERVAL  = 8'h08;
    localparam logic [7:0]  ADDR_COMMAND   = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS    = 8'h10;

    // Control field positions and mode codes
    localparam int          CTRL_SRC_BIT   = 0;
    localparam int          CTRL_SLOPE_BIT = 1;
    localparam int          CTRL_MODE_LSB  = 2;
    localparam logic [1:0]  MODE_CONT      = 2'h0;
    localparam logic [1:0]  MODE_TRIG      = 2'h1;
    localparam logic [1:0]  MODE_GATED     = 2'h2;

    // Command bits, write-only pulses
    localparam int          CMD_RUN_BIT    = 0;
    localparam int          CMD_STOP_BIT   = 1;
    localparam int          CMD_FORCE_BIT  = 2;

    // Status bits
    localparam int          STAT_RUN_BIT   = 0;
    localparam int          STAT_WAIT_BIT  = 1;
    localparam int          STAT_GATE_BIT  = 2;
    localparam int          STAT_EXT_BIT   = 3;
    localparam int          STAT_FRC_BIT   = 4;

    // Reset values
    localparam logic [3:0]  CTRL_RESET     = 4'h1;
    localparam logic [15:0] LEVEL_RESET_MV = 16'h0000;
    localparam logic [23:0] INTERVAL_RESET = 24'h0003E8;

    // Threshold limits in millivolts, two's complement
    localparam logic signed [15:0] LEVEL_MIN_MV = 16'shEC78;
    localparam logic signed [15:0] LEVEL_MAX_MV = 16'sh1388;

    // Interval limits in microseconds
    localparam logic [23:0] INTERVAL_MIN_US = 24'h000001;
    localparam logic [23:0] INTERVAL_MAX_US = 24'h989680;

    // Clock timing
    localparam int          CLK_PERIOD_NS  = 32'h00000014;
    localparam int          US_NS          = 32'h000003E8;
    localparam int          CYCLES_PER_US  = US_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_WAITING,
        ST_RUNNING
    } run_state_type;

endpackage : trig_pkg

// *** src/trig_select.sv ***
/*
 * Trigger source selection and generation for a waveform generator:
 * external comparator path, internal interval generator, force request,
 * run state and gate, plus a small software register port.
 * Assumes i_external_trigger_input is the raw output of a comparator that
 * is high while the rear trigger input is at or above the threshold that
 * o_level_mv sets, and that i_output_busy comes from the waveform engine
 * on the same clock.
 */
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module trig_select #(
    parameter int          CYCLES_PER_US   = trig_pkg::CYCLES_PER_US,
    parameter logic [23:0] INTERVAL_MAX_US = trig_pkg::INTERVAL_MAX_US
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_external_trigger_input,
    input  wire logic        i_force_trigger,
    input  wire logic        i_output_busy,
    output logic      [15:0] o_level_mv,
    output logic             o_trigger,
    output logic             o_gate,
    output logic             o_running,
    output logic             o_waiting
);

    // Reset interval kept inside the span when a small maximum is chosen,
    // so the span check holds from the first cycle after reset
    localparam logic [23:0] INTERVAL_INIT =
        (trig_pkg::INTERVAL_RESET > INTERVAL_MAX_US) ?
        INTERVAL_MAX_US : trig_pkg::INTERVAL_RESET;

    // Edge of a synchronised level; falling selects the negative slope
    function automatic logic edge_hit(input logic cur,
                                      input logic prev,
                                      input logic falling);
        edge_hit = falling ? (prev & ~cur) : (cur & ~prev);
    endfunction : edge_hit

    interval_if tmr ();

    logic [3:0]  ctrl;
    logic [15:0] level_mv;
    logic [23:0] interval_us;
    logic        run_active;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        frc_s1;
    logic        frc_s2;
    logic        frc_prev;
    logic        seen_busy;
    trig_pkg::run_state_type run_state;
    trig_pkg::run_state_type next_state;

    // Control field decode
    wire         src_int;
    wire         slope_neg;
    wire  [1:0]  mode;
    wire         mode_trig;
    wire         mode_gated;
    assign src_int    = ctrl[trig_pkg::CTRL_SRC_BIT];
    assign slope_neg  = ctrl[trig_pkg::CTRL_SLOPE_BIT];
    assign mode       = ctrl[trig_pkg::CTRL_MODE_LSB +: 2];
    assign mode_trig  = (mode == trig_pkg::MODE_TRIG);
    assign mode_gated = (mode == trig_pkg::MODE_GATED);

    // Register port decode
    wire         wr_ctrl;
    wire         wr_level;
    wire         wr_interval;
    wire         wr_cmd;
    wire         run_start;
    wire         run_stop;
    wire         sw_force;
    assign wr_ctrl     = i_wr && (i_addr == trig_pkg::ADDR_CTRL);
    assign wr_level    = i_wr && (i_addr == trig_pkg::ADDR_LEVEL);
    assign wr_interval = i_wr && (i_addr == trig_pkg::ADDR_INTERVAL);
    assign wr_cmd      = i_wr && (i_addr == trig_pkg::ADDR_COMMAND);
    // Stop wins when both command bits land in one write
    assign run_stop  = wr_cmd && i_wdata[trig_pkg::CMD_STOP_BIT];
    assign run_start = wr_cmd && i_wdata[trig_pkg::CMD_RUN_BIT] && !run_stop;
    assign sw_force  = wr_cmd && i_wdata[trig_pkg::CMD_FORCE_BIT];

    // Threshold write is clamped so the comparator DAC never leaves its span
    wire signed [15:0] level_in;
    wire        [15:0] next_level;
    assign level_in   = signed'(i_wdata[15:0]);
    assign next_level = (level_in < trig_pkg::LEVEL_MIN_MV) ?
                        trig_pkg::LEVEL_MIN_MV :
                        (level_in > trig_pkg::LEVEL_MAX_MV) ?
                        trig_pkg::LEVEL_MAX_MV : level_in;

    // Interval write clamped; any set bus bit above bit 23 saturates it to the maximum
    wire        [23:0] interval_in;
    wire        [23:0] next_interval;
    wire               interval_wide;
    assign interval_in   = i_wdata[23:0];
    assign interval_wide = |i_wdata[31:24];
    assign next_interval = (interval_wide || interval_in > INTERVAL_MAX_US) ?
                           INTERVAL_MAX_US :
                           (interval_in < trig_pkg::INTERVAL_MIN_US) ?
                           trig_pkg::INTERVAL_MIN_US : interval_in;

    // Software registers
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl        <= trig_pkg::CTRL_RESET;
            level_mv    <= trig_pkg::LEVEL_RESET_MV;
            interval_us <= INTERVAL_INIT;
        end else begin
            if (wr_ctrl)
                ctrl <= i_wdata[3:0];
            if (wr_level)
                level_mv <= next_level;
            if (wr_interval)
                interval_us <= next_interval;
        end
    end

    // Run flag follows the run and stop commands
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            run_active <= 1'b0;
        else if (run_stop)
            run_active <= 1'b0;
        else if (run_start)
            run_active <= 1'b1;
    end

    // Comparator and button are asynchronous; first flop feeds only the second
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            ext_prev <= 1'b0;
            frc_s1   <= 1'b0;
            frc_s2   <= 1'b0;
            frc_prev <= 1'b0;
        end else begin
            ext_s1   <= i_external_trigger_input;
            ext_s2   <= ext_s1;
            ext_prev <= ext_s2;
            frc_s1   <= i_force_trigger;
            frc_s2   <= frc_s1;
            frc_prev <= frc_s2;
        end
    end

    // Trigger sources; slope and level only touch the external path
    wire ext_edge;
    wire force_pulse;
    wire auto_trig;
    wire trig_req;
    wire accept;
    assign ext_edge    = edge_hit(ext_s2, ext_prev, slope_neg);
    assign force_pulse = edge_hit(frc_s2, frc_prev, 1'b0) | sw_force;
    assign auto_trig   = src_int ? tmr.tick : ext_edge;
    assign trig_req    = auto_trig | force_pulse;
    // Triggers only taken while waiting and the engine is idle
    assign accept = run_active && mode_trig &&
                    (run_state == trig_pkg::ST_WAITING) &&
                    !i_output_busy && trig_req;

    // Gate: slope acts as polarity, force button held counts as active
    wire gated_on;
    wire ext_gate;
    wire next_gate;
    assign gated_on  = run_active && mode_gated;
    assign ext_gate  = !src_int && (ext_s2 ^ slope_neg);
    assign next_gate = gated_on && (ext_gate || frc_s2);

    // Interval timer: restarted by run, off for external source or gating
    assign tmr.restart     = run_start;
    assign tmr.enable      = run_active && src_int && !mode_gated;
    assign tmr.interval_us = interval_us;

    interval_timer #(
        .CYCLES_PER_US (CYCLES_PER_US)
    ) u_timer (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .tmr     (tmr)
    );

    // Run state; triggered output returns to waiting once busy drops
    always_comb begin
        next_state = run_state;
        case (run_state)
            trig_pkg::ST_STOPPED: begin
                if (run_start)
                    next_state = mode_trig || mode_gated ?
                                 trig_pkg::ST_WAITING : trig_pkg::ST_RUNNING;
            end
            trig_pkg::ST_WAITING: begin
                if (accept || next_gate || (!mode_trig && !mode_gated))
                    next_state = trig_pkg::ST_RUNNING;
            end
            trig_pkg::ST_RUNNING: begin
                if (mode_trig && seen_busy && !i_output_busy)
                    next_state = trig_pkg::ST_WAITING;
                else if (mode_gated && !next_gate)
                    next_state = trig_pkg::ST_WAITING;
            end
            default: next_state = trig_pkg::ST_STOPPED;
        endcase
        if (run_stop || !run_active && !run_start)
            next_state = trig_pkg::ST_STOPPED;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            run_state <= trig_pkg::ST_STOPPED;
        else
            run_state <= next_state;
    end

    // Busy seen during this output; cleared outside running
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            seen_busy <= 1'b0;
        else if (run_state == trig_pkg::ST_RUNNING)
            seen_busy <= seen_busy | i_output_busy;
        else
            seen_busy <= 1'b0;
    end

    // Status word and read mux; unmapped addresses read zero
    wire [31:0] status_word;
    wire [31:0] rd_mux;
    assign status_word = {27'h0000000, frc_s2, ext_s2, o_gate,
                          run_state == trig_pkg::ST_WAITING,
                          run_state == trig_pkg::ST_RUNNING};
    assign rd_mux =
        (i_addr == trig_pkg::ADDR_CTRL)     ? {28'h0000000, ctrl}     :
        (i_addr == trig_pkg::ADDR_LEVEL)    ? {16'h0000, level_mv}    :
        (i_addr == trig_pkg::ADDR_INTERVAL) ? {8'h00, interval_us}    :
        (i_addr == trig_pkg::ADDR_STATUS)   ? status_word             :
        32'h00000000;

    // Outputs from flops; read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata   <= 32'h00000000;
            o_trigger <= 1'b0;
            o_gate    <= 1'b0;
        end else begin
            o_rdata   <= i_rd ? rd_mux : 32'h00000000;
            o_trigger <= accept;
            o_gate    <= next_gate;
        end
    end

    assign o_level_mv = level_mv;
    assign o_running  = (run_state == trig_pkg::ST_RUNNING);
    assign o_waiting  = (run_state == trig_pkg::ST_WAITING);

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    src_ext_off_a: assert property (
        !src_int |-> !tmr.enable && !tmr.tick)
        else $error("internal generator active with external source");

    ext_path_a: assert property (
        (o_trigger && !$past(src_int) && !$past(force_pulse))
        |-> $past(ext_edge))
        else $error("external trigger without an input edge");

    int_path_a: assert property (
        (o_trigger && $past(src_int) && !$past(force_pulse))
        |-> $past(tmr.tick))
        else $error("internal trigger without an interval tick");

    gate_no_tick_a: assert property (
        gated_on |-> !tmr.enable ##1 !o_trigger)
        else $error("trigger produced in gated mode");

    edge_slope_a: assert property (
        ext_edge |-> (ext_s2 != slope_neg) ##1 !ext_edge)
        else $error("edge of wrong slope or longer than one cycle");

    gate_level_a: assert property (
        $past(gated_on)
        |-> o_gate == ($past(ext_gate) || $past(frc_s2)))
        else $error("gate does not follow input or held force");

    level_span_a: assert property (
        $signed(level_mv) >= trig_pkg::LEVEL_MIN_MV &&
        $signed(level_mv) <= trig_pkg::LEVEL_MAX_MV)
        else $error("threshold outside its span");

    interval_span_a: assert property (
        interval_us >= trig_pkg::INTERVAL_MIN_US &&
        interval_us <= INTERVAL_MAX_US)
        else $error("interval outside its span");

    busy_ignore_a: assert property (
        (i_output_busy || run_state != trig_pkg::ST_WAITING) |=> !o_trigger)
        else $error("trigger taken during output");

    force_take_a: assert property (
        (force_pulse && run_active && mode_trig && !i_output_busy &&
         run_state == trig_pkg::ST_WAITING) |=> o_trigger)
        else $error("force request not taken");

    cover_ext_c:   cover property (!src_int && ext_edge ##1 o_trigger);
    cover_int_c:   cover property (src_int && tmr.tick ##1 o_trigger);
    cover_gate_c:  cover property (gated_on && ext_gate ##1 o_gate);
    cover_force_c: cover property (gated_on && frc_s2 && !ext_gate ##1 o_gate);

endmodule : trig_select

// *** tb/test_trig_select.sv ***
/*
 * Self-checking bench for the trigger selector: register port tasks,
 * internal, external, forced and gated trigger sequences.
 * Assumes the partner model stands for comparator and waveform engine.
 */
`timescale 1ns/100ps
module test_trig_select;
    localparam int          CPU  = 2;
    localparam logic [23:0] IMAX = 24'h0007D0;
    localparam int          N    = 10 * CPU;  // 10 us interval in cycles
    // Reset reads, then write and read back with compared bits
    localparam logic [7:0]  RA [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                       8'h14};
    // Status bit 3 is set: input and threshold both sit at zero after reset
    localparam logic [31:0] RE [6] = '{32'h1, 32'h0, 32'h3E8, 32'h0, 32'h8,
                                       32'h0};
    localparam logic [7:0]  WA [8] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08,
                                       8'h08, 8'h08, 8'h14};
    localparam logic [31:0] WD [8] = '{32'h1B58, 32'hFFFFE890, 32'h3E8,
                                       32'h0, 32'h01000000, 32'hBB8, 32'hA,
                                       32'hFFFFFFFF};
    localparam logic [31:0] WE [8] = '{32'h1388, 32'hEC78, 32'h3E8, 32'h1,
                                       {8'h00, IMAX}, {8'h00, IMAX}, 32'hA,
                                       32'h0};
    localparam logic [31:0] WM [8] = '{32'hFFFF, 32'hFFFF, 32'hFFFF,
                                       32'hFFFFFF, 32'hFFFFFF, 32'hFFFFFF,
                                       32'hFFFFFF, 32'hFFFFFFFF};

    logic               i_mclk;
    logic               i_rst_n;
    logic        [7:0]  i_addr;
    logic        [31:0] i_wdata;
    logic               i_wr;
    logic               i_rd;
    logic        [31:0] o_rdata;
    logic               ext_level;
    logic               force_btn;
    logic               busy;
    logic        [15:0] o_level_mv;
    logic               o_trigger;
    logic               o_gate;
    logic               o_running;
    logic               o_waiting;
    logic signed [15:0] input_mv;
    logic        [31:0] rv;
    int                 miscompares = 0;
    int                 num_checks  = 0;
    int                 cyc         = 0;
    int                 mark;
    int                 trig_q[$];

    trig_select #(.CYCLES_PER_US(CPU), .INTERVAL_MAX_US(IMAX)) dut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_external_trigger_input(ext_level), .i_force_trigger(force_btn),
        .i_output_busy(busy), .o_level_mv(o_level_mv),
        .o_trigger(o_trigger), .o_gate(o_gate), .o_running(o_running),
        .o_waiting(o_waiting));

    trig_partner partner (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_level_mv(o_level_mv),
        .i_input_mv(input_mv), .i_trigger(o_trigger),
        .o_comparator(ext_level), .o_busy(busy));

    // Clock and a watchdog against a hung run
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    initial begin
        #1000000;
        miscompares++;
        $display("Error watchdog expected end seen hang");
        complete_run();
    end

    // Trigger log by cycle number, sampled where outputs are settled
    always @(negedge i_mclk) begin
        cyc++;
        if (o_trigger === 1'b1) trig_q.push_back(cyc);
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr    <= 1'b0;
        // One idle edge so a following write never re-drives the strobe
        @(posedge i_mclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd   <= 1'b0;
        @(negedge i_mclk);
        d = o_rdata;
        @(posedge i_mclk);
    endtask : rd

    task automatic chk(input string w, input logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %0h seen %0h", w, e, g);
        end
    endtask : chk

    task automatic chk_n(input string w, input int e, input int g);
        num_checks++;
        if (g != e) begin
            miscompares++;
            $display("Error %s expected %0d seen %0d", w, e, g);
        end
    endtask : chk_n

    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick

    // Gate level settles within the sync delay; state follows the gate
    task automatic gate_is(input logic e);
        tick(5);
        @(negedge i_mclk);
        chk("gate", {31'h0, e}, {31'h0, o_gate});
        chk("running", {31'h0, e}, {31'h0, o_running});
        chk("waiting", {31'h0, ~e}, {31'h0, o_waiting});
        @(posedge i_mclk);
    endtask : gate_is

    task automatic wait_trig(input int n);
        int k;
        k = 0;
        while (trig_q.size() < n && k < 200) begin
            @(posedge i_mclk);
            k++;
        end
        if (trig_q.size() < n) begin
            miscompares++;
            $display("Error triggers expected %0d seen %0d", n, trig_q.size());
            complete_run();
        end
    endtask : wait_trig

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        i_rst_n   = 1'b0;
        i_addr    = 8'h00;
        i_wdata   = 32'h0;
        i_wr      = 1'b0;
        i_rd      = 1'b0;
        force_btn = 1'b0;
        input_mv  = 16'sd0;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        @(negedge i_mclk);
        chk("outputs", 32'h0, {o_trigger, o_gate, o_running, o_waiting});
        @(posedge i_mclk);
        for (int i = 0; i < 6; i++) begin
            rd(RA[i], rv);
            chk("reset read", RE[i], rv);
        end
        for (int i = 0; i < 8; i++) begin
            wr(WA[i], WD[i]);
            rd(WA[i], rv);
            chk("write read", WE[i], rv & WM[i]);
        end
        chk("threshold", 32'h3E8, {16'h0, o_level_mv});
        $display("Test registers done");

        // Internal source, falling slope: level crossings must do nothing
        wr(trig_pkg::ADDR_CTRL, 32'h7);
        trig_q.delete();
        wr(trig_pkg::ADDR_COMMAND, 32'h1);
        mark = cyc;
        wait_trig(1);
        input_mv <= 16'sd2000;
        tick(5);
        wr(trig_pkg::ADDR_COMMAND, 32'h4);
        wait_trig(3);
        wr(trig_pkg::ADDR_COMMAND, 32'h4);  // Lands while output is busy
        wait_trig(4);
        // Mark is taken one idle edge after the run edge, so N exactly
        chk_n("first delay", N, trig_q[0] - mark);
        chk_n("forced delay", 7, trig_q[1] - trig_q[0]);
        chk_n("period", N, trig_q[2] - trig_q[0]);
        chk_n("busy force", N, trig_q[3] - trig_q[2]);
        $display("Test internal done");

        // External source, rising then falling slope, plus the button
        input_mv <= 16'sd0;
        wr(trig_pkg::ADDR_CTRL, 32'h4);
        wr(trig_pkg::ADDR_COMMAND, 32'h1);
        trig_q.delete();
        tick(3 * N);
        chk_n("no internal", 0, trig_q.size());
        input_mv <= 16'sd2000;
        mark = cyc;
        tick(10);
        chk_n("rising", 1, trig_q.size());
        chk_n("sync delay", 4, trig_q[0] - mark);
        input_mv <= 16'sd0;
        tick(10);
        chk_n("falling ignored", 1, trig_q.size());
        wr(trig_pkg::ADDR_CTRL, 32'h6);
        tick(10);
        trig_q.delete();
        input_mv <= 16'sd2000;
        tick(10);
        chk_n("rising ignored", 0, trig_q.size());
        input_mv <= 16'sd0;
        tick(10);
        chk_n("falling", 1, trig_q.size());
        force_btn <= 1'b1;
        tick(10);
        chk_n("button", 2, trig_q.size());
        force_btn <= 1'b0;
        tick(10);
        chk_n("release", 2, trig_q.size());
        $display("Test external done");

        // Gated: internal ticks suppressed, button and level as gate
        wr(trig_pkg::ADDR_CTRL, 32'h9);
        wr(trig_pkg::ADDR_COMMAND, 32'h1);
        trig_q.delete();
        gate_is(1'b0);
        tick(3 * N);
        chk_n("gated ticks", 0, trig_q.size());
        force_btn <= 1'b1;
        gate_is(1'b1);
        tick(20);
        gate_is(1'b1);
        force_btn <= 1'b0;
        gate_is(1'b0);
        wr(trig_pkg::ADDR_CTRL, 32'h8);
        input_mv <= 16'sd1000;
        gate_is(1'b1);
        input_mv <= 16'sd999;
        gate_is(1'b0);
        wr(trig_pkg::ADDR_CTRL, 32'hA);
        gate_is(1'b1);
        input_mv <= 16'sd1000;
        gate_is(1'b0);
        $display("Test gated done");

        // Continuous mode runs at once; stop returns to stopped
        wr(trig_pkg::ADDR_CTRL, 32'h1);
        rd(trig_pkg::ADDR_STATUS, rv);
        chk("continuous", 32'h1, rv & 32'h3);
        wr(trig_pkg::ADDR_COMMAND, 32'h2);
        rd(trig_pkg::ADDR_STATUS, rv);
        chk("stopped", 32'h0, rv & 32'h3);
        $display("Test run control done");
        complete_run();
    end
endmodule : test_trig_select

// *** tb/trig_partner.sv ***
/*
 * Far-side model: rear input comparator and waveform engine busy flag.
 * Assumes the bench sets the input voltage in mV just after a clock edge.
 */
`timescale 1ns/100ps
module trig_partner #(
    parameter int BUSY_CYCLES = 3
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst_n,
    input  wire logic signed [15:0] i_level_mv,
    input  wire logic signed [15:0] i_input_mv,
    input  wire logic               i_trigger,
    output logic                    o_comparator,
    output logic                    o_busy
);
    int busy_left;

    // Comparator is high at or above the threshold
    assign o_comparator = (i_input_mv >= i_level_mv);
    assign o_busy       = (busy_left > 0);

    // One burst per trigger; a trigger during a burst does not extend it
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_left <= 0;
        end else if (i_trigger && busy_left == 0) begin
            busy_left <= BUSY_CYCLES;
        end else if (busy_left > 0) begin
            busy_left <= busy_left - 1;
        end
    end
endmodule : trig_partner
